// *** ext_int_pkg.sv ***
// Constants for the external interrupt input block
package ext_int_pkg;
    // Register byte offsets
    localparam logic [3:0] STATUS_CONTROL_OFS = 4'h0;
    localparam logic [3:0] EVT_STATUS_OFS     = 4'h4;
    localparam logic [3:0] EVT_ENABLE_OFS     = 4'h8;
    localparam logic [3:0] EVT_CLEAR_OFS      = 4'hc;
    // Status and control field positions
    localparam int SENSE_BIT   = 0;
    localparam int MASK_BIT    = 1;
    localparam int ACK_BIT     = 2;
    localparam int PENDING_BIT = 3;
    // Event status bit positions
    localparam int EVT_TRIG_BIT = 0;
    localparam int EVT_ACK_BIT  = 1;
    localparam int EVT_WIDTH    = 2;
    // Reset values
    localparam logic [7:0] STATUS_CONTROL_RST = 8'h00;
    localparam logic [1:0] EVT_RST            = 2'h0;
    localparam logic [1:0] PIN_SYNC_RST       = 2'h3;
endpackage : ext_int_pkg

// *** ext_int_input.sv ***
// External interrupt input block with Wishbone register slave
// Overview of operation
// - A falling edge on the interrupt pin sets the request latch.
// - A vector fetch acknowledge clears the latch that caused the fetch.
// - Writing 1 to the acknowledge bit clears the latch like a vector fetch.
// - Any reset clears the request latch.
// - Edge-only after reset; select bit chooses edge or edge-plus-level triggering.
// - In level mode, request stays while pin low; clears after high and acknowledge.
// - In level mode, acknowledge must follow pin return; one given while pin low is lost.
// - Reset clears the select bit, dropping a request even with pin low.
// - In edge mode an acknowledge clears the latch at once.
// - A trigger after a software acknowledge sets the latch again.
// - Read-only pending flag at bit 3 shows the request regardless of mask.
// - Mask bit 1 at one blocks the request to the CPU; zero forwards it.
// - Block runs in wait mode; unmasked request wakes the part from wait.
// - In stop mode an unmasked pin request gives an asynchronous wakeup.
// - With clear-enable high, a clear during break persists after break.
module ext_int_input
    import ext_int_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ext_int_pin_n_i,
    input  wire logic        vector_fetch_ack_i,
    input  wire logic        break_state_i,
    input  wire logic        break_clear_enable_i,
    input  wire logic        stop_mode_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             cpu_irq_req_o,
    output logic             wake_req_o,
    output logic             stop_wakeup_o,
    output logic             evt_irq_o
);

    // ==========================================================
    // Pin synchroniser and edge detect
    logic [1:0] pin_sync_r;
    logic       pin_prev_r;
    logic       fall_edge;
    logic       pin_low;

    // Runs through reset, so a pin held low gives no edge on release
    always_ff @(posedge clk_i) begin
        pin_sync_r <= {pin_sync_r[0], ext_int_pin_n_i};
        pin_prev_r <= pin_sync_r[1];
    end

    assign pin_low   = ~pin_sync_r[1];
    assign fall_edge = pin_prev_r & ~pin_sync_r[1];

    // ==========================================================
    // Bus decode
    logic bus_req;
    logic wr_en;
    logic rd_hit;
    logic ack_r;

    function automatic logic addr_known(input logic [3:0] a);
        return (a == STATUS_CONTROL_OFS) || (a == EVT_STATUS_OFS) ||
               (a == EVT_ENABLE_OFS) || (a == EVT_CLEAR_OFS);
    endfunction : addr_known

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign rd_hit  = addr_known(wb_adr_i);
    assign wr_en   = bus_req & wb_we_i & wb_sel_i[0] & rd_hit;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req;
        end
    end

    // ==========================================================
    // Control bits
    logic sense_level_r;
    logic mask_r;
    logic sc_write;
    logic sw_ack;
    logic clear_allowed;

    assign sc_write      = wr_en && (wb_adr_i == STATUS_CONTROL_OFS);
    assign clear_allowed = ~break_state_i | break_clear_enable_i;
    assign sw_ack        = sc_write & wb_dat_i[ACK_BIT] & clear_allowed;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sense_level_r <= STATUS_CONTROL_RST[SENSE_BIT];
            mask_r        <= STATUS_CONTROL_RST[MASK_BIT];
        end else if (sc_write) begin
            sense_level_r <= wb_dat_i[SENSE_BIT];
            mask_r        <= wb_dat_i[MASK_BIT];
        end
    end

    // ==========================================================
    // Request latch
    logic latch_r;
    logic any_ack;
    logic trigger;
    logic latch_nxt;

    assign any_ack = (vector_fetch_ack_i & latch_r & clear_allowed) | sw_ack;
    assign trigger = fall_edge | (sense_level_r & pin_low);

    always_comb begin
        latch_nxt = latch_r;
        if (any_ack) begin
            latch_nxt = 1'b0;
        end
        if (trigger) begin
            latch_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    assign cpu_irq_req_o = latch_r & ~mask_r;
    assign wake_req_o    = latch_r & ~mask_r;
    assign stop_wakeup_o = stop_mode_i & ~mask_r & ~ext_int_pin_n_i;

    // ==========================================================
    // Event status, enable and clear
    logic [EVT_WIDTH-1:0] evt_status_r;
    logic [EVT_WIDTH-1:0] evt_enable_r;
    logic [EVT_WIDTH-1:0] evt_set;
    logic [EVT_WIDTH-1:0] evt_clr;

    assign evt_set[EVT_TRIG_BIT] = trigger & ~latch_r;
    assign evt_set[EVT_ACK_BIT]  = any_ack & latch_r;
    assign evt_clr = (wr_en && (wb_adr_i == EVT_CLEAR_OFS)) ?
                     wb_dat_i[EVT_WIDTH-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status_r <= EVT_RST;
        end else begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_enable_r <= EVT_RST;
        end else if (wr_en && (wb_adr_i == EVT_ENABLE_OFS)) begin
            evt_enable_r <= wb_dat_i[EVT_WIDTH-1:0];
        end
    end

    assign evt_irq_o = |(evt_status_r & evt_enable_r);

    // ==========================================================
    // Read data
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i == STATUS_CONTROL_OFS) begin
            rd_data[PENDING_BIT] = latch_r;
            rd_data[MASK_BIT]    = mask_r;
            rd_data[SENSE_BIT]   = sense_level_r;
        end else if (wb_adr_i == EVT_STATUS_OFS) begin
            rd_data[EVT_WIDTH-1:0] = evt_status_r;
        end else if (wb_adr_i == EVT_ENABLE_OFS) begin
            rd_data[EVT_WIDTH-1:0] = evt_enable_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
            wb_err_o <= 1'b0;
        end else begin
            wb_dat_o <= (bus_req & ~wb_we_i) ? rd_data : 32'h0000_0000;
            wb_err_o <= bus_req & ~rd_hit;
        end
    end

    assign wb_ack_o = ack_r & ~wb_err_o;

    // ==========================================================
    // Assertions
    property p_edge_sets;
        @(posedge clk_i) disable iff (rst_i)
        (pin_prev_r && !pin_sync_r[1]) |=> latch_r;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch");

    property p_edge_ack_clears;
        @(posedge clk_i) disable iff (rst_i)
        (any_ack && !trigger && !sense_level_r) |=> !latch_r;
    endproperty
    a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("ack did not clear");

    property p_level_holds;
        @(posedge clk_i) disable iff (rst_i)
        (sense_level_r && pin_low) |=> latch_r;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level request dropped");

    property p_reset_clears;
        @(posedge clk_i) rst_i |=> (!latch_r && !sense_level_r && !mask_r);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset left state");

    property p_mask_blocks;
        @(posedge clk_i) disable iff (rst_i)
        mask_r |-> !cpu_irq_req_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked request forwarded");

    property p_break_protect;
        @(posedge clk_i) disable iff (rst_i)
        (break_state_i && !break_clear_enable_i && latch_r) |=> latch_r;
    endproperty
    a_break_protect: assert property (p_break_protect) else $error("break cleared latch");

    property p_pending_read;
        @(posedge clk_i) disable iff (rst_i)
        (bus_req && !wb_we_i && wb_adr_i == STATUS_CONTROL_OFS)
        |=> (wb_dat_o[PENDING_BIT] == $past(latch_r) && wb_dat_o[7:4] == 4'h0
             && !wb_dat_o[ACK_BIT]);
    endproperty
    a_pending_read: assert property (p_pending_read) else $error("bad status read");

    sequence s_sw_ack;
        sw_ack && !trigger;
    endsequence
    property p_sw_ack_clears;
        @(posedge clk_i) disable iff (rst_i)
        s_sw_ack ##0 !sense_level_r |=> !latch_r;
    endproperty
    a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("sw ack failed");

    // ==========================================================
    // Assertions: pin path and latch
    sequence s_pin_fall;
        pin_sync_r[1] ##1 !pin_sync_r[1];
    endsequence

    sequence s_reset_low;
        rst_i && pin_low;
    endsequence

    property p_sync_shift;
        @(posedge clk_i) disable iff (rst_i)
        pin_sync_r[1] == $past(pin_sync_r[0]);
    endproperty
    a_sync_shift: assert property (p_sync_shift) else $error("sync stalled");

    property p_fall_detect;
        @(posedge clk_i) disable iff (rst_i)
        s_pin_fall |-> fall_edge;
    endproperty
    a_fall_detect: assert property (p_fall_detect) else $error("edge missed");

    property p_fall_sets;
        @(posedge clk_i) disable iff (rst_i)
        s_pin_fall |=> latch_r;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("latch not set");

    property p_rst_low;
        @(posedge clk_i)
        s_reset_low ##1 !rst_i |-> !fall_edge;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("edge after reset");

    property p_vack_clears;
        @(posedge clk_i) disable iff (rst_i)
        (vector_fetch_ack_i && latch_r && clear_allowed && !trigger) |=> !latch_r;
    endproperty
    a_vack_clears: assert property (p_vack_clears) else $error("fetch ack failed");

    property p_retrigger;
        @(posedge clk_i) disable iff (rst_i)
        s_sw_ack ##1 fall_edge |=> latch_r;
    endproperty
    a_retrigger: assert property (p_retrigger) else $error("no retrigger");

    property p_level_low;
        @(posedge clk_i) disable iff (rst_i)
        (any_ack && sense_level_r && pin_low) |=> latch_r;
    endproperty
    a_level_low: assert property (p_level_low) else $error("level lost");

    property p_level_clear;
        @(posedge clk_i) disable iff (rst_i)
        (any_ack && sense_level_r && !trigger) |=> !latch_r;
    endproperty
    a_level_clear: assert property (p_level_clear) else $error("level kept");

    sequence s_break_clear;
        break_state_i && break_clear_enable_i && sw_ack && !trigger;
    endsequence

    property p_break_clear;
        @(posedge clk_i) disable iff (rst_i)
        s_break_clear |=> !latch_r;
    endproperty
    a_break_clear: assert property (p_break_clear) else $error("break clear lost");

    // ==========================================================
    // Assertions: outputs
    property p_rst_outputs;
        @(posedge clk_i)
        rst_i |=> (!cpu_irq_req_o && !wake_req_o && !wb_ack_o && !wb_err_o
                   && !evt_irq_o);
    endproperty
    a_rst_outputs: assert property (p_rst_outputs) else $error("output after reset");

    property p_unmasked;
        @(posedge clk_i) disable iff (rst_i)
        (latch_r && !mask_r) |-> cpu_irq_req_o;
    endproperty
    a_unmasked: assert property (p_unmasked) else $error("request held back");

    property p_wake_wait;
        @(posedge clk_i) disable iff (rst_i)
        (latch_r && !mask_r) |-> wake_req_o;
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("no wait wakeup");

    property p_wake_stop;
        @(posedge clk_i) disable iff (rst_i)
        (stop_mode_i && !mask_r && !ext_int_pin_n_i) |-> stop_wakeup_o;
    endproperty
    a_wake_stop: assert property (p_wake_stop) else $error("no stop wakeup");

    property p_stop_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (!stop_mode_i || mask_r) |-> !stop_wakeup_o;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stray wakeup");

    property p_upper_zero;
        @(posedge clk_i) disable iff (rst_i)
        wb_dat_o[31:4] == 28'h0000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_evt_trig;
        @(posedge clk_i) disable iff (rst_i)
        (trigger && !latch_r) |=> evt_status_r[EVT_TRIG_BIT];
    endproperty
    a_evt_trig: assert property (p_evt_trig) else $error("event not logged");

    // ==========================================================
    // Assertions: register bus
    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");

    property p_ack_given;
        @(posedge clk_i) disable iff (rst_i)
        (bus_req && rd_hit) |=> wb_ack_o;
    endproperty
    a_ack_given: assert property (p_ack_given) else $error("ack missing");

    property p_err_given;
        @(posedge clk_i) disable iff (rst_i)
        (bus_req && !rd_hit) |=> (wb_err_o && !wb_ack_o);
    endproperty
    a_err_given: assert property (p_err_given) else $error("err missing");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        sc_write |=> (sense_level_r == $past(wb_dat_i[SENSE_BIT])
                      && mask_r == $past(wb_dat_i[MASK_BIT]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");

endmodule : ext_int_input

// *** ext_int_src.sv ***
// Model of the external source on the active-low interrupt pin
module ext_int_src (
    input  wire logic clk_i,
    input  wire logic drive_low_i,
    output logic      pin_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released pin is pulled high
    initial pin_n_o = 1'b1;
    always @(posedge clk_i) pin_n_o <= ~drive_low_i;
endmodule : ext_int_src

// *** external_interrupt_input_bench.sv ***
// Testbench for the external interrupt input block
module external_interrupt_input_bench;
    import ext_int_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0, rst_i = 1, low = 0, vack = 0, brk = 0, bce = 0, stp = 0;
    logic        cyc = 0, stb = 0, we = 0, pin, ack, err, eb, irq, wake, swake, evt;
    logic [3:0]  adr = 0, sel = 0;
    logic [31:0] dat = 0, rd, q;
    int          err_count = 0, checked = 0, cyc_n = 0, lat = 0, mode = 0, mask = 0;
    always #4 clk_i = ~clk_i;
    ext_int_src i_ext_int_src (.clk_i(clk_i), .drive_low_i(low), .pin_n_o(pin));
    ext_int_input i_ext_int_input (.clk_i(clk_i), .rst_i(rst_i), .ext_int_pin_n_i(pin),
        .vector_fetch_ack_i(vack), .break_state_i(brk), .break_clear_enable_i(bce),
        .stop_mode_i(stp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
        .cpu_irq_req_o(irq), .wake_req_o(wake), .stop_wakeup_o(swake), .evt_irq_o(evt));
    // ==========================================
    // Tasks
    task stop_test;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
            err_count++;
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hf; dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        q = rd;
        eb = err;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask : wb
    task st;
        wb(0, STATUS_CONTROL_OFS, 8'h00);
        chk(q, 32'(lat * 8 + mask * 2 + mode));
        chk(irq, 32'(lat != 0 && mask == 0));
    endtask : st
    task pn(input logic l);
        @(posedge clk_i) low <= l;
        wt(8);
    endtask : pn
    task va;
        @(posedge clk_i) vack <= 1;
        @(posedge clk_i) vack <= 0;
        wt(2);
    endtask : va
    // ==========================================
    // Timeout
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_count++;
            stop_test;
        end
    end
    // ==========================================
    // Scenarios
    initial begin
        void'($urandom(58807));
        wt(10);
        rst_i <= 0;
        st;
        wb(1, STATUS_CONTROL_OFS, {4'($urandom), 1'($urandom), 3'h2});
        mask = 1;
        st;
        wb(0, 4'h2, 8'($urandom));
        chk(eb, 1);
        $display("test registers done");
        pn(1); lat = 1;
        st;
        wb(1, STATUS_CONTROL_OFS, 8'h00); mask = 0;
        st;
        chk(wake, 32'(lat != 0 && mask == 0));
        va; lat = 0;
        st;
        pn(0); pn(1); lat = 1;
        wb(1, STATUS_CONTROL_OFS, 8'h04); lat = 0;
        st;
        pn(0); pn(1); lat = 1;
        st;
        wb(1, STATUS_CONTROL_OFS, 8'h04); lat = 0;
        pn(0);
        $display("test edge done");
        wb(1, STATUS_CONTROL_OFS, 8'h01); mode = 1;
        pn(1); lat = 1;
        wb(1, STATUS_CONTROL_OFS, 8'h05);
        st;
        va;
        st;
        wb(1, STATUS_CONTROL_OFS, 8'h03); mask = 1;
        st;
        pn(0);
        st;
        wb(1, STATUS_CONTROL_OFS, 8'h05); lat = 0; mask = 0;
        st;
        pn(1);
        @(posedge clk_i) rst_i <= 1;
        wt(2);
        chk(irq, 0);
        rst_i <= 0;
        wt(6);
        chk(irq, 0);
        mode = 0; lat = 0;
        st;
        pn(0);
        wb(1, STATUS_CONTROL_OFS, 8'h04);
        st;
        $display("test level done");
        pn(1); pn(0); lat = 1;
        @(posedge clk_i) brk <= 1;
        wb(1, STATUS_CONTROL_OFS, 8'h04);
        va;
        st;
        @(posedge clk_i) bce <= 1;
        wb(1, STATUS_CONTROL_OFS, 8'h04); lat = 0;
        @(posedge clk_i) brk <= 0;
        @(posedge clk_i) bce <= 0;
        st;
        $display("test break done");
        wb(1, EVT_CLEAR_OFS, 8'h03);
        wb(1, EVT_ENABLE_OFS, 8'h01);
        pn(1); pn(0);
        wb(0, EVT_STATUS_OFS, 8'h00);
        chk(q, 1);
        chk(evt, 1);
        wb(1, EVT_ENABLE_OFS, 8'h00);
        chk(evt, 0);
        wb(1, STATUS_CONTROL_OFS, 8'h04);
        wb(0, EVT_STATUS_OFS, 8'h00);
        chk(q, 3);
        wb(1, EVT_CLEAR_OFS, 8'h03);
        wb(0, EVT_STATUS_OFS, 8'h00);
        chk(q, 0);
        $display("test events done");
        @(posedge clk_i) stp <= 1;
        low <= 1;
        wt(3);
        chk(swake, 1);
        wb(1, STATUS_CONTROL_OFS, 8'h02);
        chk(swake, 0);
        $display("test stop done");
        stop_test;
    end
endmodule : external_interrupt_input_bench
